// ### pkg/frp_defs.vh
// Constants for the FIFO read port block
`ifndef FRP_DEFS_VH
`define FRP_DEFS_VH

// ************************************************************
// Widths and depth
// ************************************************************
`define FRP_DATA_W        18
`define FRP_NARROW_W      9
`define FRP_ADDR_W        4
`define FRP_PTR_W         5
`define FRP_DEPTH         16
`define FRP_OFF_W         4
`define FRP_OFFS_W        8
`define FRP_BITIDX_W      3
`define FRP_BUF_CNT_W     2

// ************************************************************
// Reset values and buffer full count
// ************************************************************
`define FRP_PTR_RST       5'h00
`define FRP_DATA_RST      18'h00000
`define FRP_OFFS_RST      8'h77
`define FRP_BITIDX_RST    3'h0
`define FRP_BUF_CNT_RST   2'h0
`define FRP_BUF_FULL      2'h2

// ************************************************************
// Synchroniser bit positions
// ************************************************************
`define FRP_SYNC_W        14
`define FRP_S_RCLK        0
`define FRP_S_SCLK        1
`define FRP_S_REN_N       2
`define FRP_S_RSEL_N      3
`define FRP_S_RT_N        4
`define FRP_S_MARK        5
`define FRP_S_LD_N        6
`define FRP_S_SEN_N       7
`define FRP_S_FT_SI       8
`define FRP_S_PCLR_N      9
`define FRP_S_FCLR_N      10
`define FRP_S_OE_N        11
`define FRP_S_ASYNC       12
`define FRP_S_NARROW      13
`define FRP_SYNC_RST      14'h0000

`endif

// ### hdl/frp_buf.v
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "frp_defs.vh"

module frp_buf (
    input  wire                     clk_sys_in,   // System clock
    input  wire                     arst_n_in,    // Async reset, active low
    input  wire                     clear_in,     // Sync flush
    input  wire                     in_valid_in,  // Source word valid
    input  wire [`FRP_DATA_W-1:0]   in_data_in,   // Source word
    output wire                     in_ready_out, // Room for a word
    output wire                     out_valid_out,// Word available
    output wire [`FRP_DATA_W-1:0]   out_data_out, // Oldest word
    input  wire                     out_ready_in  // Sink takes word
);
    reg [`FRP_DATA_W-1:0]   d0_q;
    reg [`FRP_DATA_W-1:0]   d1_q;
    reg [`FRP_BUF_CNT_W-1:0] cnt_q;
    reg [`FRP_BUF_CNT_W-1:0] cnt_d;
    reg                     rdy_q;
    wire                    push;
    wire                    pop;

    assign out_valid_out = (cnt_q != `FRP_BUF_CNT_RST);
    assign out_data_out  = d0_q;
    assign in_ready_out  = rdy_q;
    assign push          = in_valid_in & rdy_q;
    assign pop           = out_valid_out & out_ready_in;

    always @* begin
        cnt_d = cnt_q;
        if (clear_in) begin
            cnt_d = `FRP_BUF_CNT_RST;
        end else if (push & ~pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= `FRP_BUF_CNT_RST;
            rdy_q <= 1'b0;
            d0_q  <= `FRP_DATA_RST;
            d1_q  <= `FRP_DATA_RST;
        end else begin
            cnt_q <= cnt_d;
            // Ready registered from next fill, so no word is dropped
            rdy_q <= ~clear_in & (cnt_d != `FRP_BUF_FULL);
            if (pop) begin
                d0_q <= (push && cnt_q == 2'h1) ? in_data_in : d1_q;
                if (push && cnt_q == `FRP_BUF_FULL) begin
                    d1_q <= in_data_in;
                end
            end else if (push) begin
                if (cnt_q == `FRP_BUF_CNT_RST) begin
                    d0_q <= in_data_in;
                end else begin
                    d1_q <= in_data_in;
                end
            end
        end
    end
endmodule

// ### hdl/frp_top.v
// Read port of a FIFO: resets, reads, retransmit, mark and offset load
`timescale 1ns/1ps
`include "frp_defs.vh"

// Contract
// - Partial clear zeroes read and write pointers and the output data register.
// - Partial clear keeps timing mode, programming method and offset values.
// - Data bus is 18 bits, or 9 bits in narrow mode, upper bits zero.
// - Synchronous mode: read clock edge with read enable reads one word or offsets.
// - Offset access low: synchronous-mode read clock edge puts offset registers on data outputs.
// - Asynchronous mode: each read strobe rising edge with offset access high reads one word.
// - Read select gates reads and output drive, sampled on read clock.
// - During resets read select ignored; output enable alone controls drive.
// - Retransmit on read clock edge rewinds read pointer, forces empty indication.
// - Retransmit leaves write pointer, method, timing mode and offsets alone.
// - With a recorded mark, retransmit loads the marked position instead of zero.
// - Serial clock edge with shift enable shifts serial bit into offsets.
// - Mark input records current read pointer for later retransmit.
// - After full clear, the fall-through strap pin is the serial data input.
module frp_top (
    input  wire                     clk_sys_in,               // System clock 20 MHz
    input  wire                     arst_n_in,                // Async reset, active low
    input  wire                     rd_clk_strobe_in,         // Read clock or strobe
    input  wire                     serial_clk_in,            // Serial offset clock
    input  wire                     read_enable_n_in,         // Read enable, active low
    input  wire                     read_select_n_in,         // Read chip select, low
    input  wire                     replay_request_n_in,      // Retransmit, active low
    input  wire                     mark_in,                  // Mark read position
    input  wire                     offset_access_n_in,       // Offset access, low
    input  wire                     offset_shift_enable_n_in, // Serial enable, low
    input  wire                     fall_through_mode_in,     // Strap, then serial data
    input  wire                     partial_clear_n_in,       // Partial clear, low
    input  wire                     full_clear_n_in,          // Full clear, low
    input  wire                     output_enable_n_in,       // Output enable, low
    input  wire                     async_read_sel_in,        // Strap: strobe read mode
    input  wire                     narrow_sel_in,            // Strap: 9-bit output
    input  wire                     wr_valid_in,              // Write word valid
    input  wire [`FRP_DATA_W-1:0]   wr_data_in,               // Write word
    output wire                     wr_ready_out,             // Write side ready
    output reg  [`FRP_DATA_W-1:0]   read_data_out,            // Output data register
    output reg                      data_oe_out,              // Data bus drive enable
    output reg                      empty_flag_n_out,         // Empty / output-ready
    output reg                      full_flag_n_out           // Full flag, active low
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    wire [`FRP_SYNC_W-1:0] raw;
    reg  [`FRP_SYNC_W-1:0] s1_q;
    reg  [`FRP_SYNC_W-1:0] s2_q;

    assign raw = {narrow_sel_in, async_read_sel_in, output_enable_n_in,
                  full_clear_n_in, partial_clear_n_in, fall_through_mode_in,
                  offset_shift_enable_n_in, offset_access_n_in, mark_in,
                  replay_request_n_in, read_select_n_in, read_enable_n_in,
                  serial_clk_in, rd_clk_strobe_in};

    genvar g;
    generate
        for (g = 0; g < `FRP_SYNC_W; g = g + 1) begin : g_sync
            always @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    reg [`FRP_DATA_W-1:0]   mem [0:`FRP_DEPTH-1];
    reg [`FRP_PTR_W-1:0]    wr_ptr_q;
    reg [`FRP_PTR_W-1:0]    rd_ptr_q;
    reg [`FRP_PTR_W-1:0]    mark_ptr_q;
    reg                     mark_vld_q;
    reg                     out_vld_q;
    reg                     ft_q;
    reg                     async_q;
    reg                     narrow_q;
    reg [`FRP_OFFS_W-1:0]   offs_q;
    reg [`FRP_BITIDX_W-1:0] bit_idx_q;
    reg                     rclk_prev_q;
    reg                     sclk_prev_q;
    reg                     rsel_n_q;

    wire                    in_full_clr = ~s2_q[`FRP_S_FCLR_N];
    wire                    in_clr = in_full_clr | ~s2_q[`FRP_S_PCLR_N];
    wire                    rclk_rise = s2_q[`FRP_S_RCLK] & ~rclk_prev_q;
    wire                    sclk_rise = s2_q[`FRP_S_SCLK] & ~sclk_prev_q;
    wire                    sel_ok = ~s2_q[`FRP_S_RSEL_N];
    wire [`FRP_PTR_W-1:0]   fill = wr_ptr_q - rd_ptr_q;
    wire                    empty = (fill == `FRP_PTR_RST);
    wire                    full = fill[`FRP_PTR_W-1];
    wire                    buf_vld;
    wire [`FRP_DATA_W-1:0]  buf_data;
    wire                    wr_take = buf_vld & ~full & ~in_clr;
    wire [`FRP_DATA_W-1:0]  mem_word = mem[rd_ptr_q[`FRP_ADDR_W-1:0]];
    // narrow mode, upper bits carry zero
    wire [`FRP_DATA_W-1:0]  out_word = narrow_q ?
        {{(`FRP_DATA_W-`FRP_NARROW_W){1'b0}}, mem_word[`FRP_NARROW_W-1:0]} : mem_word;
    // synchronous read needs enable and select
    wire                    sync_rd = ~async_q & rclk_rise & ~s2_q[`FRP_S_REN_N] & sel_ok;
    wire                    async_rd = async_q & rclk_rise & sel_ok;
    wire                    off_rd = sync_rd & ~s2_q[`FRP_S_LD_N];
    wire                    mem_rd = (sync_rd | async_rd) & s2_q[`FRP_S_LD_N];
    wire                    replay = rclk_rise & ~s2_q[`FRP_S_RT_N];
    wire                    ft_fill = ft_q & ~out_vld_q & ~empty;

    // ************************************************************
    // Write side buffer and memory
    // ************************************************************
    frp_buf u_buf (
        .clk_sys_in    (clk_sys_in),
        .arst_n_in     (arst_n_in),
        .clear_in      (in_clr),
        .in_valid_in   (wr_valid_in),
        .in_data_in    (wr_data_in),
        .in_ready_out  (wr_ready_out),
        .out_valid_out (buf_vld),
        .out_data_out  (buf_data),
        .out_ready_in  (wr_take)
    );

    always @(posedge clk_sys_in) begin
        if (wr_take) begin
            mem[wr_ptr_q[`FRP_ADDR_W-1:0]] <= buf_data;
        end
    end

    // write pointer cleared, retransmit never touches it
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_q <= `FRP_PTR_RST;
        end else if (in_clr) begin
            wr_ptr_q <= `FRP_PTR_RST;
        end else if (wr_take) begin
            wr_ptr_q <= wr_ptr_q + 5'h01;
        end
    end

    // ************************************************************
    // Straps and offset registers
    // ************************************************************
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ft_q        <= 1'b0;
            async_q     <= 1'b0;
            narrow_q    <= 1'b0;
            offs_q      <= `FRP_OFFS_RST;
            bit_idx_q   <= `FRP_BITIDX_RST;
            rclk_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            rclk_prev_q <= s2_q[`FRP_S_RCLK];
            sclk_prev_q <= s2_q[`FRP_S_SCLK];
            // only full clear reloads modes and offsets
            if (in_full_clr) begin
                ft_q      <= s2_q[`FRP_S_FT_SI];
                async_q   <= s2_q[`FRP_S_ASYNC];
                narrow_q  <= s2_q[`FRP_S_NARROW];
                offs_q    <= `FRP_OFFS_RST;
                bit_idx_q <= `FRP_BITIDX_RST;
            // serial shift, strap pin as data, LSB first, wraps
            end else if (sclk_rise & ~s2_q[`FRP_S_SEN_N]) begin
                offs_q[bit_idx_q] <= s2_q[`FRP_S_FT_SI];
                bit_idx_q         <= bit_idx_q + 3'h1;
            end
        end
    end

    // ************************************************************
    // Read pointer, mark and output register
    // ************************************************************
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_ptr_q      <= `FRP_PTR_RST;
            mark_ptr_q    <= `FRP_PTR_RST;
            mark_vld_q    <= 1'b0;
            out_vld_q     <= 1'b0;
            read_data_out <= `FRP_DATA_RST;
            rsel_n_q      <= 1'b1;
        end else begin
            if (rclk_rise) begin
                rsel_n_q <= s2_q[`FRP_S_RSEL_N];
            end
            if (in_clr) begin
                rd_ptr_q      <= `FRP_PTR_RST;
                mark_vld_q    <= 1'b0;
                out_vld_q     <= 1'b0;
                read_data_out <= `FRP_DATA_RST;
            end else if (replay) begin
                rd_ptr_q  <= mark_vld_q ? mark_ptr_q : `FRP_PTR_RST;
                out_vld_q <= 1'b0;
            end else begin
                if (s2_q[`FRP_S_MARK]) begin
                    mark_ptr_q <= rd_ptr_q;
                    mark_vld_q <= 1'b1;
                end
                if (off_rd) begin
                    read_data_out <= {{(`FRP_DATA_W-`FRP_OFFS_W){1'b0}}, offs_q};
                // word taken only when memory holds one
                end else if ((mem_rd | ft_fill) & ~empty) begin
                    read_data_out <= out_word;
                    rd_ptr_q      <= rd_ptr_q + 5'h01;
                    out_vld_q     <= 1'b1;
                end else if (mem_rd & ft_q) begin
                    out_vld_q <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Flags and output drive
    // ************************************************************
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            empty_flag_n_out <= 1'b0;
            full_flag_n_out  <= 1'b1;
            data_oe_out      <= 1'b0;
        end else begin
            // forced empty low, or output-ready high in fall-through
            if (in_clr | replay) begin
                empty_flag_n_out <= ft_q;
            end else begin
                empty_flag_n_out <= ft_q ? ~out_vld_q : ~empty;
            end
            full_flag_n_out <= ~full;
            // select ignored in reset, otherwise it gates drive
            if (in_clr) begin
                data_oe_out <= ~s2_q[`FRP_S_OE_N];
            end else begin
                data_oe_out <= ~s2_q[`FRP_S_OE_N] & ~rsel_n_q;
            end
        end
    end
endmodule

// ### test/frp_checker.sv
// Assertion checker for the FIFO read port block
`timescale 1ns/1ps
`include "frp_defs.vh"

module frp_checker (
    input logic                   clk_sys_in,           // Clock
    input logic                   arst_n_in,            // Reset
    input logic                   rd_clk_strobe_in,     // Read clock
    input logic                   read_enable_n_in,     // Read enable
    input logic                   read_select_n_in,     // Select
    input logic                   replay_request_n_in,  // Retransmit
    input logic                   offset_access_n_in,   // Offset access
    input logic                   fall_through_mode_in, // Strap
    input logic                   partial_clear_n_in,   // Partial clear
    input logic                   full_clear_n_in,      // Full clear
    input logic                   output_enable_n_in,   // Drive enable
    input logic                   narrow_sel_in,        // Narrow strap
    input logic [`FRP_DATA_W-1:0] read_data_out,        // Data
    input logic                   data_oe_out,          // Drive
    input logic                   empty_flag_n_out      // Empty flag
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);

    logic ft_q;
    wire  calm = full_clear_n_in & partial_clear_n_in & replay_request_n_in;

    // Mode captured during full clear
    always @(posedge clk_sys_in or negedge arst_n_in)
        if (!arst_n_in)
            ft_q <= 1'h0;
        else if (!full_clear_n_in)
            ft_q <= fall_through_mode_in;

    a_pclr_data_zero: assert property (
        (!partial_clear_n_in)[*5] |-> read_data_out == 18'h00000)
        else $error("data not cleared by partial clear");
    a_pclr_keep_mode: assert property (
        (!partial_clear_n_in)[*5] |-> empty_flag_n_out == ft_q)
        else $error("timing mode lost in partial clear");
    a_clear_oe_only: assert property (
        (!partial_clear_n_in && $stable(output_enable_n_in))[*5]
        |-> data_oe_out == !output_enable_n_in) else $error("drive wrong during clear");
    a_fclr_ft_empty: assert property (
        (!full_clear_n_in && fall_through_mode_in)[*5] |-> empty_flag_n_out)
        else $error("fall-through empty indication wrong");
    a_oe_high_off: assert property (output_enable_n_in[*4] |-> !data_oe_out)
        else $error("bus driven with enable high");
    a_narrow_upper: assert property (
        narrow_sel_in[*3] |-> read_data_out[`FRP_DATA_W-1:`FRP_NARROW_W] == 9'h000)
        else $error("upper bits set in narrow mode");
    a_replay_flag: assert property (
        $rose(rd_clk_strobe_in) && !replay_request_n_in |-> ##[2:6] empty_flag_n_out == ft_q)
        else $error("retransmit did not set empty indication");
    a_unselected_hold: assert property (
        !ft_q && calm && read_select_n_in && $rose(rd_clk_strobe_in)
        |-> ##1 (!calm || !read_select_n_in || $stable(read_data_out))[*5])
        else $error("read done while deselected");
    a_read_advances: assert property (
        !ft_q && calm && !read_select_n_in && !read_enable_n_in && offset_access_n_in
        && empty_flag_n_out && $rose(rd_clk_strobe_in) |-> ##[2:5] $changed(read_data_out))
        else $error("enabled read left data unchanged");
endmodule

bind frp_top frp_checker chk (.*);

// ### test/frp_reader.sv
// Downstream reader model driving read clock and read controls
`timescale 1ns/1ps

module frp_reader (
    output logic rd_clk_out, // Read clock or strobe
    output logic ren_n_out,  // Read enable, low
    output logic rsel_n_out  // Read select, low
);
    initial begin
        rd_clk_out = 1'h0;
        ren_n_out  = 1'h1;
        rsel_n_out = 1'h1;
    end

    // controls held through the whole clock period
    task cycle(input logic en_n, input logic sel_n);
        ren_n_out  = en_n;
        rsel_n_out = sel_n;
        #200 rd_clk_out = 1'h1;
        #200 rd_clk_out = 1'h0;
    endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the FIFO read port block
`timescale 1ns/1ps
`include "frp_defs.vh"

module tb;
    logic clk_sys_in, arst_n_in, serial_clk_in, mark_in, wr_valid_in;
    logic rd_clk_strobe_in, read_enable_n_in, read_select_n_in, replay_request_n_in;
    logic offset_access_n_in, offset_shift_enable_n_in, fall_through_mode_in;
    logic partial_clear_n_in, full_clear_n_in, output_enable_n_in;
    logic async_read_sel_in, narrow_sel_in, wr_ready_out, data_oe_out;
    logic empty_flag_n_out, full_flag_n_out;
    logic [`FRP_DATA_W-1:0] wr_data_in, read_data_out;
    logic [7:0]             sv;
    int                     num_errors, n_checks, i;

    frp_top dut (.*);
    frp_reader rdr (.rd_clk_out(rd_clk_strobe_in), .ren_n_out(read_enable_n_in),
                    .rsel_n_out(read_select_n_in));

    initial begin
        clk_sys_in = 1'h0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask
    task chk_w(input string nm, input logic [17:0] e, input logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_b(input string nm, input logic e, input logic g);
        chk_w(nm, {17'h0, e}, {17'h0, g});
    endtask
    task conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task clr(input logic full, input logic ft, input logic asy, input logic nar);
        full_clear_n_in    = !full;
        partial_clear_n_in = full;
        tick(4);
        fall_through_mode_in = ft;
        async_read_sel_in    = asy;
        narrow_sel_in        = nar;
        tick(7);
        full_clear_n_in    = 1'h1;
        partial_clear_n_in = 1'h1;
        tick(3);
    endtask
    task wr(input logic [17:0] w);
        int k;
        wr_valid_in = 1'h1;
        wr_data_in  = w;
        for (k = 0; wr_ready_out !== 1'h1; k++) begin
            if (k == 30) begin
                chk_b("wr_ready_out", 1'h1, wr_ready_out);
                conclude();
            end
            tick(1);
        end
        tick(1);
        wr_valid_in = 1'h0;
        tick(1);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task s_std();
        clr(1'h1, 1'h0, 1'h0, 1'h0);
        for (i = 1; i < 4; i++)
            wr(18'h00A00 + 18'(i));
        tick(4);
        rdr.cycle(1'h0, 1'h0);
        chk_w("read_data_out", 18'h00A01, read_data_out);
        mark_in = 1'h1;
        tick(4);
        mark_in = 1'h0;
        rdr.cycle(1'h0, 1'h0);
        rdr.cycle(1'h0, 1'h0);
        chk_w("read_data_out", 18'h00A03, read_data_out);
        replay_request_n_in = 1'h0;
        rdr.cycle(1'h1, 1'h0);
        replay_request_n_in = 1'h1;
        rdr.cycle(1'h0, 1'h0);
        chk_w("read_data_out", 18'h00A02, read_data_out);
        rdr.cycle(1'h0, 1'h0);
        rdr.cycle(1'h0, 1'h0);
        chk_w("read_data_out", 18'h00A03, read_data_out);
        chk_b("empty_flag_n_out", 1'h0, empty_flag_n_out);
    endtask
    task s_off();
        offset_access_n_in = 1'h0;
        rdr.cycle(1'h0, 1'h0);
        chk_w("offsets", 18'h00077, read_data_out);
        sv = 8'hA5;
        offset_shift_enable_n_in = 1'h0;
        for (i = 0; i < 8; i++) begin
            fall_through_mode_in = sv[i];
            #200 serial_clk_in = 1'h1;
            #200 serial_clk_in = 1'h0;
        end
        offset_shift_enable_n_in = 1'h1;
        rdr.cycle(1'h0, 1'h0);
        chk_w("offsets", 18'h000A5, read_data_out);
        clr(1'h0, 1'h0, 1'h0, 1'h0);
        chk_w("read_data_out", 18'h00000, read_data_out);
        rdr.cycle(1'h0, 1'h0);
        chk_w("offsets", 18'h000A5, read_data_out);
        offset_access_n_in = 1'h1;
    endtask
    task s_sel();
        wr(18'h00B01);
        rdr.cycle(1'h0, 1'h1);
        chk_w("read_data_out", 18'h000A5, read_data_out);
        chk_b("data_oe_out", 1'h0, data_oe_out);
        rdr.cycle(1'h0, 1'h0);
        chk_w("read_data_out", 18'h00B01, read_data_out);
        chk_b("data_oe_out", 1'h1, data_oe_out);
        output_enable_n_in = 1'h1;
        tick(5);
        chk_b("data_oe_out", 1'h0, data_oe_out);
        output_enable_n_in = 1'h0;
        rdr.cycle(1'h1, 1'h1);
        partial_clear_n_in = 1'h0;
        tick(6);
        chk_b("data_oe_out", 1'h1, data_oe_out);
        partial_clear_n_in = 1'h1;
        tick(3);
    endtask
    task s_ft();
        clr(1'h1, 1'h1, 1'h0, 1'h1);
        wr(18'h3FFFF);
        tick(6);
        chk_b("empty_flag_n_out", 1'h0, empty_flag_n_out);
        chk_w("read_data_out", 18'h001FF, read_data_out);
        rdr.cycle(1'h0, 1'h0);
        chk_b("empty_flag_n_out", 1'h1, empty_flag_n_out);
        replay_request_n_in = 1'h0;
        rdr.cycle(1'h1, 1'h0);
        replay_request_n_in = 1'h1;
        tick(6);
        chk_b("empty_flag_n_out", 1'h0, empty_flag_n_out);
    endtask
    task s_async();
        clr(1'h1, 1'h0, 1'h1, 1'h0);
        for (i = 0; i < 18; i++)
            wr(18'h00C00 + 18'(i));
        wr_valid_in = 1'h1;
        tick(3);
        chk_b("full_flag_n_out", 1'h0, full_flag_n_out);
        chk_b("wr_ready_out", 1'h0, wr_ready_out);
        wr_valid_in = 1'h0;
        for (i = 0; i < 18; i++) begin
            rdr.cycle(1'h0, 1'h0);
            chk_w("read_data_out", 18'h00C00 + 18'(i), read_data_out);
        end
        chk_b("empty_flag_n_out", 1'h0, empty_flag_n_out);
    endtask

    initial begin
        {serial_clk_in, mark_in, wr_valid_in, narrow_sel_in, async_read_sel_in} = 5'h00;
        {fall_through_mode_in, output_enable_n_in, arst_n_in} = 3'h0;
        {replay_request_n_in, offset_access_n_in, offset_shift_enable_n_in} = 3'h7;
        {partial_clear_n_in, full_clear_n_in} = 2'h3;
        wr_data_in = 18'h00000;
        num_errors = 0;
        n_checks   = 0;
        tick(4);
        arst_n_in = 1'h1;
        s_std();
        s_off();
        s_sel();
        s_ft();
        s_async();
        conclude();
    end
endmodule
